//--- src/fsc_params.svh
// constants of the command block
// assumes a 100 MHz clock; included by the top
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// ****************
// timing
// ****************
`define FSC_CLK_NS       10
`define FSC_TICK_NS      1000000
`define FSC_TICK_CYC     (`FSC_TICK_NS / `FSC_CLK_NS)
`define FSC_STEP_PW_NS   1000
`define FSC_STEP_PW_CYC  (`FSC_STEP_PW_NS / `FSC_CLK_NS)

// ****************
// register map (byte offsets)
// ****************
`define FSC_OFF_DATA     8'h00
`define FSC_OFF_MAIN     8'h04
`define FSC_OFF_CTRL     8'h08
`define FSC_OFF_STAT     8'h0C

// control fields, reset values
`define FSC_CTL_EXT      0
`define FSC_CTL_WILD     1
`define FSC_CTL_NDMA     2
`define FSC_CTL_SRST     3
`define FSC_CTL_SRT_LSB  8
`define FSC_CTL_MNT_LSB  16
`define FSC_SRT_RST      8'h08
`define FSC_MNT_RST      8'h04

// main status bits
`define FSC_MS_RQM       7
`define FSC_MS_DIO       6
`define FSC_MS_NDMA      5
`define FSC_MS_BUSY      4

// ****************
// command codes and lengths
// ****************
`define FSC_OP_SEEK      8'h0F
`define FSC_OP_SINT      8'h08
`define FSC_OP_SDRV      8'h04
`define FSC_OP_SCAN_EQ   5'h11
`define FSC_OP_SCAN_HE   5'h1D
`define FSC_OP_SCAN_LE   5'h19
`define FSC_LEN_SCAN     4'h9
`define FSC_LEN_SEEK     4'h3
`define FSC_LEN_SDRV     4'h2
`define FSC_LEN_ONE      4'h1
`define FSC_SEL_HEAD     2

// ****************
// status codes
// ****************
`define FSC_C_RDY        3'b110
`define FSC_C_SEEK_OK    3'b001
`define FSC_C_SEEK_BAD   3'b011
`define FSC_INVALID      8'h80
`define FSC_SR2_EQ       3
`define FSC_SR2_NOTMET   2

`endif

//--- src/fsc_pkg.sv
// types of the command block
// assumes nothing else
package fsc_pkg;

    // engine phases, gray in the order idle-cmd-motor-scan-result
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CMD   = 3'b001,
        S_MOTOR = 3'b011,
        S_SCAN  = 3'b010,
        S_RES   = 3'b110
    } fsc_state_t;

    // whole state of the block
    typedef struct packed {
        fsc_state_t         st;
        logic [8:0][7:0]    cb;
        logic [3:0]         ncb;
        logic [6:0][7:0]    res;
        logic [2:0]         nres;
        logic [2:0]         ridx;
        logic [1:0]         sint_src;
        logic [3:0][11:0]   ptr;
        logic [11:0]        tgt;
        logic [1:0]         sdrv;
        logic               shead;
        logic [3:0]         sbusy;
        logic               seek_ph;
        logic [7:0]         tcnt;
        logic [7:0]         mcnt;
        logic [7:0]         pw;
        logic [19:0]        tick;
        logic               step;
        logic               dir;
        logic               int_res;
        logic               seek_pend;
        logic [7:0]         seek_sr0;
        logic               rdy_pend;
        logic [7:0]         rdy_sr0;
        logic [3:0]         rdy1;
        logic [3:0]         rdy2;
        logic [3:0]         rdy3;
        logic [1:0]         wp;
        logic [1:0]         trk0;
        logic [2:0]         dstb;
        logic [2:0]         dsec;
        logic [2:0]         tcs;
        logic [7:0]         dd1;
        logic [7:0]         dd2;
        logic [7:0]         hb;
        logic               hbv;
        logic               eq;
        logic               lt;
        logic [7:0]         sec;
        logic               ext;
        logic               wild;
        logic               ndma;
        logic [7:0]         srt;
        logic [7:0]         mnt;
        logic               ap;
        logic               aw;
        logic [7:0]         aa;
        logic [31:0]        hrd;
        logic               hrdy;
        logic               hresp;
        logic               irq;
    } fsc_reg_t;

endpackage

//--- src/fsc_top.sv
// scan, seek, drive-status and sense command engine with
// an AHB-Lite register port and floppy drive step/status pins
// assumes one 100 MHz clock; drive pins are asynchronous
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fsc_params.svh"

// Summary of operation
// - opcode top flags, low five bits scan type
// - select byte: head bit2, drive bits1..0
// - scan nine bytes in, seven result bytes
// - seek compares target with track each step, sets direction
// - seek sets per-drive busy bit
// - motor-on delay before first step
// - after delay go idle, step in background
// - steps spaced at programmed step rate
// - interrupt one period after last step
// - fourth seek byte when extended range on
// - drive status returns one byte, no interrupt
// - sense returns sr0, track low, optional nibble
// - interrupt on scan result entry and non-DMA byte
// - ready change on polled drive interrupts
// - seek termination raises interrupt
// - result/transfer interrupt cleared by data access
// - ready/seek interrupt cleared by first sense byte
// - cause in sr0 bits 7..5
// - sense with nothing pending is invalid
// - scan sectors until met, last sector, or count
// - sr2 bit3 equal, bit2 not met
// - wildcard all-ones byte compares equal
// - codes 110 ready, 001 normal, 011 abnormal
module fsc_top #(
    parameter int TICK_CYC = `FSC_TICK_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [3:0]  drv_ready_i,
    input  wire logic        drv_wprot_i,
    input  wire logic        drv_trk0_i,
    input  wire logic [7:0]  disk_data_i,
    input  wire logic        disk_strobe_i,
    input  wire logic        sector_end_i,
    input  wire logic        terminal_count_in_i,
    output logic             step_o,
    output logic             dir_o,
    output logic             head_select_o,
    output logic      [1:0]  drive_select_o,
    output logic             irq_o
);

    fsc_pkg::fsc_reg_t q;
    fsc_pkg::fsc_reg_t d;

    logic       wr_data;
    logic       rd_data;
    logic       tick_p;
    logic       go;
    logic       met;
    logic       res_ev;
    logic       req_ev;
    logic       seek_set;
    logic       rdy_set;
    logic       clr_seek;
    logic       clr_rdy;
    logic [7:0] wb;
    logic [7:0] op;
    logic [7:0] sel;
    logic [3:0] rdiff;
    logic [11:0] cur;

    // ****************
    // command length decode
    // ****************
    function automatic logic [3:0] cmd_len(input logic [7:0] o, input logic ext);
        logic [4:0] t;
        t = o[4:0];
        if (t == `FSC_OP_SCAN_EQ || t == `FSC_OP_SCAN_HE || t == `FSC_OP_SCAN_LE)
            cmd_len = `FSC_LEN_SCAN;
        else if (o == `FSC_OP_SEEK)
            cmd_len = `FSC_LEN_SEEK + {3'b000, ext};
        else if (o == `FSC_OP_SDRV)
            cmd_len = `FSC_LEN_SDRV;
        else
            cmd_len = `FSC_LEN_ONE;
    endfunction

    function automatic logic is_scan(input logic [7:0] o);
        is_scan = (o[4:0] == `FSC_OP_SCAN_EQ) || (o[4:0] == `FSC_OP_SCAN_HE)
                  || (o[4:0] == `FSC_OP_SCAN_LE);
    endfunction

    // ****************
    // next-state logic
    // ****************
    always_comb begin
        d        = q;
        wr_data  = 1'b0;
        rd_data  = 1'b0;
        go       = 1'b0;
        met      = 1'b0;
        res_ev   = 1'b0;
        req_ev   = 1'b0;
        seek_set = 1'b0;
        rdy_set  = 1'b0;
        clr_seek = 1'b0;
        clr_rdy  = 1'b0;
        wb       = hwdata_i[7:0];
        // two flops per pin, a third where edges are detected
        d.rdy1 = drv_ready_i;
        d.rdy2 = q.rdy1;
        d.rdy3 = q.rdy2;
        d.wp   = {q.wp[0], drv_wprot_i};
        d.trk0 = {q.trk0[0], drv_trk0_i};
        d.dstb = {q.dstb[1:0], disk_strobe_i};
        d.dsec = {q.dsec[1:0], sector_end_i};
        d.tcs  = {q.tcs[1:0], terminal_count_in_i};
        d.dd1  = disk_data_i;
        d.dd2  = q.dd1;
        rdiff  = q.rdy2 ^ q.rdy3;
        cur    = q.ptr[q.sdrv];

        // ms tick and step pulse width
        tick_p = (q.tick == 20'(TICK_CYC - 1));
        d.tick = tick_p ? 20'h0000_0 : q.tick + 20'h0000_1;
        d.pw   = (q.pw != 8'h00) ? q.pw - 8'h01 : 8'h00;

        // bus slave: one wait cycle per access
        d.hrdy  = 1'b1;
        d.hresp = 1'b0;
        if (q.ap) begin
            d.ap = 1'b0;
            if (q.aw) begin
                wr_data = (q.aa == `FSC_OFF_DATA);
                if (q.aa == `FSC_OFF_CTRL) begin
                    d.ext  = hwdata_i[`FSC_CTL_EXT];
                    d.wild = hwdata_i[`FSC_CTL_WILD];
                    d.ndma = hwdata_i[`FSC_CTL_NDMA];
                    d.srt  = hwdata_i[`FSC_CTL_SRT_LSB +: 8];
                    d.mnt  = hwdata_i[`FSC_CTL_MNT_LSB +: 8];
                end
            end else begin
                rd_data = (q.aa == `FSC_OFF_DATA) && (q.st == fsc_pkg::S_RES);
                unique case (q.aa)
                    `FSC_OFF_DATA: d.hrd = rd_data ? {24'h0000_00, q.res[q.ridx]} : 32'h0000_0000;
                    `FSC_OFF_MAIN: begin
                        d.hrd = 32'h0000_0000;
                        d.hrd[`FSC_MS_RQM]  = (q.st != fsc_pkg::S_MOTOR && q.st != fsc_pkg::S_SCAN)
                                              || (q.st == fsc_pkg::S_SCAN && q.ndma && !q.hbv);
                        d.hrd[`FSC_MS_DIO]  = (q.st == fsc_pkg::S_RES);
                        d.hrd[`FSC_MS_NDMA] = (q.st == fsc_pkg::S_SCAN) && q.ndma;
                        d.hrd[`FSC_MS_BUSY] = (q.st != fsc_pkg::S_IDLE);
                        d.hrd[3:0]          = q.sbusy;
                    end
                    `FSC_OFF_CTRL: d.hrd = {8'h00, q.mnt, q.srt, 5'h00, q.ndma, q.wild, q.ext};
                    `FSC_OFF_STAT: d.hrd = {13'h0000, q.st, q.seek_ph, q.rdy_pend, q.seek_pend,
                                            q.int_res, cur};
                    default:       d.hrd = 32'h0000_0000;
                endcase
            end
        end
        if (hsel_i && htrans_i[1] && hready_i) begin
            d.ap   = 1'b1;
            d.aw   = hwrite_i;
            d.aa   = haddr_i[7:0];
            d.hrdy = 1'b0;
        end

        // command bytes collect, host scan bytes land
        if (wr_data) begin
            unique case (q.st)
                fsc_pkg::S_IDLE: begin
                    d.cb[0] = wb;
                    d.ncb   = 4'h1;
                    d.st    = fsc_pkg::S_CMD;
                    go      = (cmd_len(wb, q.ext) == `FSC_LEN_ONE);
                end
                fsc_pkg::S_CMD: begin
                    d.cb[q.ncb] = wb;
                    d.ncb       = q.ncb + 4'h1;
                    go          = (q.ncb + 4'h1 == cmd_len(q.cb[0], q.ext));
                end
                fsc_pkg::S_SCAN: begin
                    d.hb  = wb;
                    d.hbv = 1'b1;
                end
                default: ;
            endcase
        end
        op  = d.cb[0];
        sel = d.cb[1];

        // dispatch of a complete command
        if (go) begin
            d.ncb  = 4'h0;
            d.ridx = 3'h0;
            d.sint_src = 2'h0;
            d.st   = fsc_pkg::S_RES;
            if (is_scan(op)) begin
                d.sdrv  = sel[1:0];
                d.shead = sel[`FSC_SEL_HEAD];
                d.sec   = d.cb[4];
                d.eq    = 1'b1;
                d.lt    = 1'b0;
                d.hbv   = 1'b0;
                req_ev  = q.ndma;
                d.st    = fsc_pkg::S_SCAN;
            end else if (op == `FSC_OP_SEEK) begin
                d.sdrv  = sel[1:0];
                d.shead = sel[`FSC_SEL_HEAD];
                d.tgt   = q.ext ? {d.cb[3][7:4], d.cb[2]} : {4'h0, d.cb[2]};
                d.sbusy[sel[1:0]] = 1'b1;
                d.mcnt  = q.mnt;
                d.st    = fsc_pkg::S_MOTOR;
            end else if (op == `FSC_OP_SDRV) begin
                // one byte of drive status, no interrupt
                d.res[0] = {1'b0, q.wp[1], q.rdy2[sel[1:0]], q.trk0[1], 1'b1,
                            sel[`FSC_SEL_HEAD], sel[1:0]};
                d.nres   = 3'h1;
            end else if (op == `FSC_OP_SINT && (q.seek_pend || q.rdy_pend)) begin
                d.sint_src = q.seek_pend ? 2'h1 : 2'h2;
                d.res[0]   = q.seek_pend ? q.seek_sr0 : q.rdy_sr0;
                d.res[1]   = q.ptr[d.res[0][1:0]][7:0];
                d.res[2]   = {q.ptr[d.res[0][1:0]][11:8], 4'h0};
                d.nres     = q.ext ? 3'h3 : 3'h2;
            end else begin
                // unknown opcode, or sense with nothing pending
                d.res[0] = `FSC_INVALID;
                d.nres   = 3'h1;
            end
        end

        // result drain; first sense byte clears cause
        if (rd_data) begin
            d.ridx   = q.ridx + 3'h1;
            clr_seek = (q.ridx == 3'h0) && (q.sint_src == 2'h1);
            clr_rdy  = (q.ridx == 3'h0) && (q.sint_src == 2'h2);
            if (q.ridx + 3'h1 == q.nres) begin
                d.st   = fsc_pkg::S_IDLE;
                d.ridx = 3'h0;
            end
        end

        // simulated motor-on wait, then back to idle
        if (q.st == fsc_pkg::S_MOTOR && tick_p) begin
            if (q.mcnt == 8'h00) begin
                d.st      = fsc_pkg::S_IDLE;
                d.seek_ph = 1'b1;
                d.tcnt    = 8'h00;
            end else begin
                d.mcnt = q.mcnt - 8'h01;
            end
        end

        // scan: first differing byte decides
        if (q.st == fsc_pkg::S_SCAN) begin
            if (q.dstb[1] && !q.dstb[2] && q.hbv) begin
                d.hbv  = 1'b0;
                req_ev = q.ndma;
                if (!(q.wild && (q.dd2 == 8'hFF || q.hb == 8'hFF))
                    && q.eq && q.dd2 != q.hb) begin
                    d.eq = 1'b0;
                    d.lt = (q.dd2 < q.hb);
                end
            end
            if ((q.dsec[1] && !q.dsec[2]) || (q.tcs[1] && !q.tcs[2])) begin
                unique case (q.cb[0][4:0])
                    `FSC_OP_SCAN_HE: met = !q.lt;
                    `FSC_OP_SCAN_LE: met = q.eq || q.lt;
                    default:         met = q.eq;
                endcase
                // stop on met, last sector, or terminal count
                if (met || (q.tcs[1] && !q.tcs[2]) || q.sec == q.cb[6]) begin
                    d.res[0] = {5'h00, q.shead, q.sdrv};
                    d.res[1] = 8'h00;
                    d.res[2] = 8'h00;
                    d.res[2][`FSC_SR2_EQ]     = met && q.eq;
                    d.res[2][`FSC_SR2_NOTMET] = !met;
                    d.res[3] = q.cb[2];
                    d.res[4] = q.cb[3];
                    d.res[5] = q.sec;
                    d.res[6] = q.cb[5];
                    d.nres   = 3'h7;
                    d.ridx   = 3'h0;
                    d.st     = fsc_pkg::S_RES;
                    res_ev   = 1'b1;
                end else begin
                    d.sec = q.sec + q.cb[8];
                    d.eq  = 1'b1;
                    d.lt  = 1'b0;
                end
            end
        end

        // background stepper while idle; dir moves only with a new step
        if (q.seek_ph && tick_p) begin
            if (q.tcnt != 8'h00) begin
                d.tcnt = q.tcnt - 8'h01;
            end else if (cur != q.tgt) begin
                d.pw   = 8'(`FSC_STEP_PW_CYC);
                d.dir  = (q.tgt > cur);
                d.ptr[q.sdrv] = (q.tgt > cur) ? cur + 12'h001 : cur - 12'h001;
                d.tcnt = q.srt;
            end else begin
                // a step period after the last pulse
                d.seek_ph = 1'b0;
                d.sbusy[q.sdrv] = 1'b0;
                d.seek_sr0 = {q.rdy2[q.sdrv] ? `FSC_C_SEEK_OK : `FSC_C_SEEK_BAD,
                              2'b00, q.shead, q.sdrv};
                seek_set = 1'b1;
            end
        end
        d.step = (d.pw != 8'h00);

        // ready polling, armed from reset onward
        if (rdiff != 4'h0) begin
            rdy_set   = 1'b1;
            d.rdy_sr0 = {`FSC_C_RDY, 5'h00};
            for (int i = 3; i >= 0; i--) begin
                if (rdiff[i]) begin
                    d.rdy_sr0[1:0] = 2'(i);
                end
            end
        end

        // sticky causes: set beats clear
        if (rd_data || wr_data) begin
            d.int_res = 1'b0;
        end
        if (res_ev || req_ev) begin
            d.int_res = 1'b1;
        end
        if (clr_seek) begin
            d.seek_pend = 1'b0;
        end
        if (seek_set) begin
            d.seek_pend = 1'b1;
        end
        if (clr_rdy) begin
            d.rdy_pend = 1'b0;
        end
        if (rdy_set) begin
            d.rdy_pend = 1'b1;
        end

        // soft reset clears the engine, keeps settings
        if (q.ap && q.aw && q.aa == `FSC_OFF_CTRL && hwdata_i[`FSC_CTL_SRST]) begin
            d.st        = fsc_pkg::S_IDLE;
            d.ncb       = 4'h0;
            d.seek_ph   = 1'b0;
            d.sbusy     = 4'h0;
            d.int_res   = 1'b0;
            d.seek_pend = 1'b0;
            d.rdy_pend  = 1'b0;
        end
        d.irq = d.int_res || d.seek_pend || d.rdy_pend;
    end

    // ****************
    // state register
    // ****************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q      <= '0;
            q.hrdy <= 1'b1;
            q.srt  <= `FSC_SRT_RST;
            q.mnt  <= `FSC_MNT_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign hrdata_o       = q.hrd;
    assign hreadyout_o    = q.hrdy;
    assign hresp_o        = q.hresp;
    assign step_o         = q.step;
    assign dir_o          = q.dir;
    assign head_select_o  = q.shead;
    assign drive_select_o = q.sdrv;
    assign irq_o          = q.irq;

endmodule

//--- dv/fsc_chk_sva.sv
// port checker for the command engine
// assumes fsc_top ports, one clock
`timescale 1ns/1ps
module fsc_chk #(
    parameter int TICK_CYC = 10
) (
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [3:0]  drv_ready_i,
    input wire logic        step_o,
    input wire logic        dir_o,
    input wire logic [1:0]  drive_select_o,
    input wire logic        irq_o
);
    // ****************
    // helpers
    // ****************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic        acc;
    logic [7:0]  hi_q;
    logic [15:0] gap_q;
    logic [2:0]  age_q;
    assign acc = hsel_i && htrans_i[1] && hready_i;
    // step width, step spacing, access age
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hi_q  <= 8'h00;
            gap_q <= 16'hffff;
            age_q <= 3'h7;
        end else begin
            hi_q  <= step_o ? hi_q + 8'h01 : 8'h00;
            gap_q <= $rose(step_o) ? 16'h0001 : gap_q + {15'h0, gap_q != 16'hffff};
            age_q <= (acc && haddr_i[7:0] inside {8'h00, 8'h08}) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
        end
    end
    // ****************
    // properties
    // ****************
    wait_one_a: assert property (acc |=> !hreadyout_o ##1 hreadyout_o) else $error("bad data phase");
    idle_ready_a: assert property (!acc |=> hreadyout_o) else $error("stray wait");
    resp_okay_a: assert property (!hresp_o) else $error("not okay");
    rdata_hold_a: assert property ($changed(hrdata_o) |-> $past(!hreadyout_o)) else $error("read data moved");
    step_width_a: assert property ($fell(step_o) |-> hi_q == 8'h64) else $error("step width");
    step_gap_a: assert property ($rose(step_o) |-> gap_q > 16'h0064 && gap_q >= TICK_CYC)
        else $error("step gap");
    step_dir_a: assert property (step_o && $past(step_o) |-> $stable(dir_o) && $stable(drive_select_o))
        else $error("dir moved");
    irq_clear_a: assert property ($fell(irq_o) |-> age_q < 3'h5) else $error("irq drop");
    ready_irq_a: assert property ($changed(drv_ready_i) |-> ##[1:8] irq_o) else $error("no ready irq");
    cover property ($rose(step_o));
    cover property ($fell(irq_o));
    cover property (acc ##2 acc);
endmodule
bind fsc_top fsc_chk #(.TICK_CYC(TICK_CYC)) u_fsc_chk (.sys_clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .drv_ready_i, .step_o, .dir_o, .drive_select_o, .irq_o);

//--- dv/fsc_drive.sv
// drive model: head, ready lines, disk bytes
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/1ps
module fsc_drive (
    input  wire logic       sys_clk_i,
    input  wire logic       step_i,
    input  wire logic       dir_i,
    output logic      [3:0] drv_ready_o,
    output logic            drv_trk0_o,
    output logic      [7:0] disk_data_o,
    output logic            disk_strobe_o,
    output logic            sector_end_o
);
    logic [11:0] track = 12'h000;
    logic        st_q = 1'b0;
    initial begin
        drv_ready_o   = 4'hf;
        disk_data_o   = 8'h00;
        disk_strobe_o = 1'b0;
        sector_end_o  = 1'b0;
    end
    assign drv_trk0_o = (track == 12'h000);
    // one track per step rise
    always @(posedge sys_clk_i) begin
        st_q <= step_i;
        if (step_i && !st_q) track <= dir_i ? track + 12'h001 : track - 12'h001;
    end
    // byte held around the strobe, then inverted
    task automatic disk_byte(input logic [7:0] b);
        disk_data_o <= b;
        repeat (4) @(posedge sys_clk_i);
        disk_strobe_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        disk_strobe_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        disk_data_o <= ~b;
    endtask
    // end-of-sector mark
    task automatic sector_done;
        sector_end_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        sector_end_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
endmodule

//--- dv/floppy_scan_seek_sense_cmds_test.sv
// bench for the command engine over AHB-Lite
// assumes fsc_top, fsc_drive and the bound checker
`timescale 1ns/1ps
`include "fsc_params.svh"
module floppy_scan_seek_sense_cmds_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hrdy, hresp, step, dir, head, irq, trk0, strobe, send;
    logic [1:0]  dsel;
    logic [3:0]  rdy;
    logic [7:0]  ddata;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    fsc_top #(.TICK_CYC(10)) u_fsc_top (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .drv_ready_i(rdy), .drv_wprot_i(1'b0),
        .drv_trk0_i(trk0), .disk_data_i(ddata), .disk_strobe_i(strobe), .sector_end_i(send),
        .terminal_count_in_i(1'b0), .step_o(step), .dir_o(dir), .head_select_o(head),
        .drive_select_o(dsel), .irq_o(irq));
    fsc_drive u_fsc_drive (.sys_clk_i(clk), .step_i(step), .dir_i(dir), .drv_ready_o(rdy),
        .drv_trk0_o(trk0), .disk_data_o(ddata), .disk_strobe_o(strobe), .sector_end_o(send));
    initial forever #5 clk = ~clk;
    // watchdog, long seek ~30k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            final_report();
        end
    end
    // ****************
    // bus and compare tasks
    // ****************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0000_0000, r);
    endtask
    task automatic wb(input logic [7:0] b);
        logic [31:0] x;
        bus(1'b1, 8'h00, {24'h00_0000, b}, x);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
    endtask
    task automatic final_report;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // sense: cause, then track
    task automatic sense(input logic [7:0] c, input logic [11:0] t, input logic e);
        logic [31:0] x;
        wb(`FSC_OP_SINT);
        rd(8'h00, x);
        chk(x[7:0] & 8'he0, c);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        rd(8'h00, x);
        chk(x[7:0], t[7:0]);
        if (e) rd(8'h00, x);
        if (e) chk(x[7:0], {t[11:8], 4'h0});
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_ready(input logic drop);
        if (drop) u_fsc_drive.drv_ready_o[3] <= 1'b0;
        wait_irq();
        sense(8'hc0, 12'h000, 1'b0);
        $display("ready done");
    endtask
    task automatic t_other;
        logic [31:0] x;
        wb(`FSC_OP_SINT);
        rd(8'h00, x);
        chk(x[7:0], `FSC_INVALID);
        wb(`FSC_OP_SDRV);
        wb(8'h05);
        rd(8'h00, x);
        chk(x[7:0], 8'h3d);
        chk({7'h0, irq}, 8'h00);
        rd(8'h04, x);
        chk(x[7:0] & 8'h40, 8'h00);
        $display("other done");
    endtask
    task automatic t_scan(input logic [4:0] op, input logic [7:0] hb, db, input logic wild, input logic [7:0] sr2);
        logic [7:0]  cmd [9];
        logic [31:0] x;
        cmd = '{{3'b010, op}, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1b, 8'h01};
        bus(1'b1, 8'h08, {16'h0004, 8'h08, 6'h00, wild, 1'b0}, x);
        foreach (cmd[i]) wb(cmd[i]);
        chk({7'h0, irq}, 8'h00);
        wb(hb);
        u_fsc_drive.disk_byte(db);
        u_fsc_drive.sector_done();
        wait_irq();
        for (int i = 0; i < 7; i++) begin
            rd(8'h00, x);
            if (i == 0) repeat (2) @(posedge clk);
            if (i == 0) chk({7'h0, irq}, 8'h00);
            if (i == 2) chk(x[7:0] & 8'h0c, sr2);
            if (i == 3) chk(x[7:0], 8'h00);
        end
        rd(8'h04, x);
        chk(x[7:0] & 8'h40, 8'h00);
        $display("scan done");
    endtask
    task automatic t_seek(input logic e, input logic [11:0] t);
        logic [31:0] x;
        logic        up;
        up = t > u_fsc_drive.track;
        bus(1'b1, 8'h08, {16'h0001, 8'h0a, 7'h00, e}, x);
        wb(`FSC_OP_SEEK);
        wb(8'h01);
        wb(t[7:0]);
        if (e) wb({t[11:8], 4'h0});
        rd(8'h04, x);
        chk(x[7:0] & 8'h02, 8'h02);
        chk({7'h0, step}, 8'h00);
        repeat (200) @(posedge clk);
        rd(8'h04, x);
        chk(x[7:0] & 8'h12, 8'h02);
        wait_irq();
        chk({7'h0, dir}, {7'h0, up});
        chk({5'h0, head, dsel}, 8'h01);
        chk(u_fsc_drive.track[7:0], t[7:0]);
        sense(8'h20, t, e);
        $display("seek done");
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_ready(1'b0);
        t_other();
        t_scan(`FSC_OP_SCAN_EQ, 8'h5a, 8'h5a, 1'b0, 8'h08);
        t_scan(`FSC_OP_SCAN_HE, 8'h10, 8'h20, 1'b0, 8'h00);
        t_scan(`FSC_OP_SCAN_LE, 8'h10, 8'h20, 1'b0, 8'h04);
        t_scan(`FSC_OP_SCAN_EQ, 8'hff, 8'h33, 1'b1, 8'h08);
        t_ready(1'b1);
        t_seek(1'b0, 12'h005);
        t_seek(1'b1, 12'h102);
        final_report();
    end
endmodule
